// ### shared/ire_regs.vh
// Constants for the infrared pulse encoder/decoder.
// Assumes a 25 MHz core clock and a UART with 16 baud ticks per bit.
//
// Overview of operation
// - Every bit spans sixteen baud ticks.
// - Transmit one keeps the output low throughout.
// - Transmit zero: low seven, high three, low six.
// - Enabled: modulated signal drives the transmit pin.
// - Enabled: decoded stream, not raw pin, feeds UART.
// - Half duplex; no simultaneous transmit and receive.
// - Timing from baud divisor: clock/(16*divisor).
// - Rates 9600 to 115200 baud are supported.
// - Receive tick counter runs zero through fifteen.
// - Decoded stream lags input by eight ticks.
// - Falling edge while idle or in window resets the receive tick counter.
// - At count eight, update the decoded output.
// - Window opens at twelve, closes at eight.
// - Pulse in window repeats; none returns idle.
// - Resynchronizing never disturbs the UART receiver.
`ifndef IRE_REGS_VH
`define IRE_REGS_VH

`define IRE_TICKS_PER_BIT 16
`define IRE_PHASE_LAST 4'hF
`define IRE_PULSE_FIRST 4'h7
`define IRE_PULSE_LAST 4'h9
`define IRE_RX_UPDATE 4'h8
`define IRE_RX_WINDOW 4'hC
`define IRE_DIV_WIDTH 16
`define IRE_FIFO_DEPTH 16
`define IRE_CLK_HZ 25000000
`define IRE_MIN_CLK_HZ 1000000
`define IRE_RST_LINE 1'b1
`define IRE_RST_IR 1'b0

`endif

// ### hw/ire_fifo.v
// Synchronous FIFO of bits waiting for the encoder.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
`default_nettype none
module ire_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire resetn,
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output reg in_ready,
    output reg out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    reg [AW:0] next_count;
    wire push;
    wire pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule
`default_nettype wire

// ### hw/ire_encoder.v
// Pulse encoder: one queued bit per sixteen baud ticks.
// Assumes baud_tick is a one-clock pulse at sixteen per bit.
`timescale 1ns/1ps
`default_nettype none
`include "ire_regs.vh"
module ire_encoder (
    input wire core_clk,
    input wire resetn,
    input wire baud_tick,
    input wire enable,
    input wire bit_valid,
    input wire bit_data,
    output wire bit_take,
    output reg ir_out,
    output reg busy
);
    reg [3:0] phase;
    reg cur_bit;
    reg active;
    wire at_end;

    assign at_end = (phase == `IRE_PHASE_LAST);
    // Take a new bit only on a bit boundary
    assign bit_take = enable && baud_tick && bit_valid
        && (!active || at_end);

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 4'h0;
            cur_bit <= `IRE_RST_LINE;
            active <= 1'b0;
            ir_out <= `IRE_RST_IR;
            busy <= 1'b0;
        end else begin
            if (!enable) begin
                active <= 1'b0;
                phase <= 4'h0;
            end else if (bit_take) begin
                cur_bit <= bit_data;
                active <= 1'b1;
                phase <= 4'h0;
            end else if (baud_tick && active) begin
                phase <= phase + 1'b1;
                if (at_end) begin
                    active <= 1'b0;
                end
            end
            // Zero gets a three-tick pulse after seven low ticks
            ir_out <= enable && active && !cur_bit
                && (phase >= `IRE_PULSE_FIRST)
                && (phase <= `IRE_PULSE_LAST);
            busy <= enable && (active || bit_valid);
        end
    end
endmodule
`default_nettype wire

// ### hw/ire_endec.v
// Top of the infrared pulse encoder/decoder with baud tick source.
// Assumes pin and UART signals are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ire_regs.vh"
module ire_endec #(
    parameter DIV_WIDTH = `IRE_DIV_WIDTH,
    parameter FIFO_DEPTH = `IRE_FIFO_DEPTH,
    parameter FIFO_AW = 4
) (
    input wire core_clk,
    input wire resetn,
    input wire uart_enable,
    input wire infrared_enable_bit,
    input wire [DIV_WIDTH-1:0] baud_divisor,
    input wire uart_txd,
    input wire uart_tx_valid,
    input wire uart_tx_bit,
    output wire uart_tx_ready,
    output reg txd_pin,
    input wire ir_pulse_in,
    output reg uart_rxd,
    output reg baud_tick_out,
    output reg tx_busy,
    output reg rx_active
);
    localparam ST_IDLE = 3'b001;
    localparam ST_FIRST = 3'b010;
    localparam ST_WINDOW = 3'b100;

    reg [DIV_WIDTH-1:0] div_cnt;
    reg baud_tick;
    reg [2:0] rx_state;
    reg [2:0] next_rx_state;
    reg [3:0] rx_cnt;
    reg [3:0] next_rx_cnt;
    reg rx_demod;
    reg next_rx_demod;
    reg pin_prev;
    wire ir_on;
    wire fall;
    wire fifo_valid;
    wire fifo_bit;
    wire enc_take;
    wire enc_ir;
    wire enc_busy;
    wire fifo_in_ready;

    assign ir_on = infrared_enable_bit && uart_enable;
    assign fall = pin_prev && !ir_pulse_in;
    assign uart_tx_ready = fifo_in_ready;

    // Baud tick: one pulse every divisor clocks, sixteen per bit
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= {DIV_WIDTH{1'b0}};
            baud_tick <= 1'b0;
        end else if (!uart_enable) begin
            div_cnt <= {DIV_WIDTH{1'b0}};
            baud_tick <= 1'b0;
        end else if (div_cnt + 1'b1 >= baud_divisor) begin
            div_cnt <= {DIV_WIDTH{1'b0}};
            baud_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            baud_tick <= 1'b0;
        end
    end

    ire_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_valid(uart_tx_valid && ir_on),
        .in_data(uart_tx_bit),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_bit),
        .out_ready(enc_take)
    );

    ire_encoder u_enc (
        .core_clk(core_clk),
        .resetn(resetn),
        .baud_tick(baud_tick),
        .enable(ir_on),
        .bit_valid(fifo_valid),
        .bit_data(fifo_bit),
        .bit_take(enc_take),
        .ir_out(enc_ir),
        .busy(enc_busy)
    );

    // Receive decoder
    always @* begin
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt;
        next_rx_demod = rx_demod;
        if (!ir_on || enc_busy) begin
            // Own transmission must not be read back
            next_rx_state = ST_IDLE;
            next_rx_cnt = 4'h0;
            next_rx_demod = `IRE_RST_LINE;
        end else begin
            case (rx_state)
                ST_IDLE: begin
                    if (fall) begin
                        next_rx_state = ST_FIRST;
                        next_rx_cnt = 4'h0;
                    end
                end
                ST_FIRST: begin
                    if (baud_tick) begin
                        next_rx_cnt = rx_cnt + 1'b1;
                        if (next_rx_cnt == `IRE_RX_UPDATE) begin
                            next_rx_demod = 1'b0;
                        end
                        if (next_rx_cnt == `IRE_RX_WINDOW) begin
                            next_rx_state = ST_WINDOW;
                            // Pulse on the opening tick is inside
                            if (fall) begin
                                next_rx_state = ST_FIRST;
                                next_rx_cnt = 4'h0;
                            end
                        end
                    end
                end
                ST_WINDOW: begin
                    if (fall) begin
                        // Pulse in window starts the next decode
                        next_rx_state = ST_FIRST;
                        next_rx_cnt = 4'h0;
                    end else if (baud_tick) begin
                        next_rx_cnt = rx_cnt + 1'b1;
                        if (next_rx_cnt == `IRE_RX_UPDATE) begin
                            next_rx_demod = 1'b1;
                            next_rx_state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_rx_state = ST_IDLE;
                    next_rx_cnt = 4'h0;
                    next_rx_demod = `IRE_RST_LINE;
                end
            endcase
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_state <= ST_IDLE;
            rx_cnt <= 4'h0;
            rx_demod <= `IRE_RST_LINE;
            pin_prev <= `IRE_RST_LINE;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            rx_demod <= next_rx_demod;
            pin_prev <= ir_pulse_in;
        end
    end

    // Pin and UART steering, all outputs registered
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            txd_pin <= `IRE_RST_LINE;
            uart_rxd <= `IRE_RST_LINE;
            baud_tick_out <= 1'b0;
            tx_busy <= 1'b0;
            rx_active <= 1'b0;
        end else begin
            if (ir_on) begin
                txd_pin <= enc_ir;
                uart_rxd <= rx_demod;
            end else begin
                txd_pin <= uart_txd;
                uart_rxd <= ir_pulse_in;
            end
            baud_tick_out <= baud_tick;
            tx_busy <= enc_busy;
            rx_active <= (rx_state != ST_IDLE);
        end
    end
endmodule
`default_nettype wire

// ### sim/ire_endec_assertions.sv
// Port checker for the infrared endec top.
// Assumes bind from the bench; cycle counts hold for divisor one.
`timescale 1ns/1ps
`default_nettype none
module ire_endec_assertions #(
    parameter DIV_WIDTH = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic uart_enable,
    input wire logic infrared_enable_bit,
    input wire logic [DIV_WIDTH-1:0] baud_divisor,
    input wire logic uart_txd,
    input wire logic uart_tx_valid,
    input wire logic uart_tx_bit,
    input wire logic uart_tx_ready,
    input wire logic txd_pin,
    input wire logic ir_pulse_in,
    input wire logic uart_rxd,
    input wire logic baud_tick_out,
    input wire logic tx_busy,
    input wire logic rx_active
);
    wire logic on = uart_enable && infrared_enable_bit;
    wire logic div1 = baud_divisor == 1;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_pass_tx; !on |=> txd_pin == $past(uart_txd); endproperty
    property p_pass_rx; !on |=> uart_rxd == $past(ir_pulse_in); endproperty
    property p_pulse;
        on && $past(on) && div1 && $rose(txd_pin) |-> txd_pin[*3] ##1 !txd_pin;
    endproperty
    property p_gap;
        on && $past(on) && div1 && $fell(txd_pin) |-> (!txd_pin)[*8];
    endproperty
    property p_idle_low; (on && !tx_busy)[*3] |-> !txd_pin; endproperty
    property p_rx_lag;
        (on && div1 && !tx_busy && !rx_active)[*2] ##0 $fell(ir_pulse_in)
            |-> uart_rxd[*7] ##[1:5] !uart_rxd;
    endproperty
    property p_rx_hold; on && div1 && $fell(uart_rxd) |-> (!uart_rxd)[*8];
    endproperty
    property p_half; (on && tx_busy)[*3] |-> uart_rxd && !rx_active;
    endproperty
    property p_tick; (uart_enable && div1)[*3] |-> baud_tick_out; endproperty
    a_pass_tx: assert property (p_pass_tx)
        else $error("pin differs from raw transmit");
    a_pass_rx: assert property (p_pass_rx)
        else $error("receive output differs from pin");
    a_pulse: assert property (p_pulse)
        else $error("pulse not three ticks");
    a_gap: assert property (p_gap)
        else $error("low gap too short");
    a_idle_low: assert property (p_idle_low)
        else $error("output high while idle");
    a_rx_lag: assert property (p_rx_lag)
        else $error("decoded low not eight ticks late");
    a_rx_hold: assert property (p_rx_hold)
        else $error("decoded low too short");
    a_half: assert property (p_half)
        else $error("decoder active while sending");
    a_tick: assert property (p_tick)
        else $error("missing baud tick");
    c_pulse: cover property (on && $rose(txd_pin));
    c_rx: cover property (on && $fell(uart_rxd));
    c_full: cover property (on && uart_tx_valid && !uart_tx_ready);
endmodule
`default_nettype wire

// ### sim/ire_xcvr.sv
// Infrared transceiver model: sends pulses, watches the transmit pin.
// Assumes divisor one, so one baud tick per clock.
`timescale 1ns/1ps
`default_nettype none
module ire_xcvr (
    input wire logic core_clk,
    input wire logic txd_pin,
    output logic ir_pulse_in
);
    logic level = 1'b1;
    logic prev = 1'b0;
    int cyc = 0, pulses = 0, last_rise = 0, span = 0, width = 0;
    assign ir_pulse_in = level;
    // Active low pulse of three ticks per zero, idle high
    task send(input logic b);
        for (int i = 0; i < 16; i++) begin
            level = !(b == 1'b0 && i < 3);
            @(posedge core_clk);
            #1;
        end
        level = 1'b1;
    endtask
    // Two pulses, the second one gap ticks after the first
    task pair(input int gap);
        for (int i = 0; i < gap + 3; i++) begin
            level = !(i < 3 || i >= gap);
            @(posedge core_clk);
            #1;
        end
        level = 1'b1;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        prev <= txd_pin;
        if (txd_pin && !prev) begin
            pulses++;
            span = cyc - last_rise;
            last_rise = cyc;
            width = 0;
        end
        if (txd_pin) begin
            width++;
        end
    end
endmodule
`default_nettype wire

// ### sim/infrared_pulse_endec_bench.sv
// Self-checking bench for the infrared endec top.
// Assumes the transceiver model and the port checker beside it.
`timescale 1ns/1ps
`default_nettype none
module infrared_pulse_endec_bench;
    logic core_clk = 0, resetn = 0, uart_enable = 0;
    logic infrared_enable_bit = 0, uart_txd = 1;
    logic uart_tx_valid = 0, uart_tx_bit = 1;
    logic [15:0] baud_divisor = 16'h0001;
    wire logic uart_tx_ready, txd_pin, ir_pulse_in, uart_rxd;
    wire logic baud_tick_out, tx_busy, rx_active;
    int bad_count = 0, compares = 0, cyc = 0, n, f, l;
    always #20 core_clk = ~core_clk;
    ire_endec uut (.core_clk(core_clk), .resetn(resetn),
        .uart_enable(uart_enable), .infrared_enable_bit(infrared_enable_bit),
        .baud_divisor(baud_divisor), .uart_txd(uart_txd),
        .uart_tx_valid(uart_tx_valid), .uart_tx_bit(uart_tx_bit),
        .uart_tx_ready(uart_tx_ready), .txd_pin(txd_pin),
        .ir_pulse_in(ir_pulse_in), .uart_rxd(uart_rxd),
        .baud_tick_out(baud_tick_out), .tx_busy(tx_busy),
        .rx_active(rx_active));
    ire_xcvr peer (.core_clk(core_clk), .txd_pin(txd_pin),
        .ir_pulse_in(ir_pulse_in));
    task chk(input string name, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", name, e, g);
        end
    endtask
    task conclude;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task wait_idle;
        for (int i = 0; i < 400 && tx_busy !== 1'b0; i++) step(1);
        chk("tx_busy", 0, tx_busy);
    endtask
    task t_pass;
        for (int v = 0; v < 2; v++) begin
            uart_txd = v;
            peer.level = v;
            step(2);
            chk("txd_pin", v, txd_pin);
            chk("uart_rxd", v, uart_rxd);
        end
    endtask
    task t_tx;
        n = peer.pulses;
        fork begin step(4); peer.send(0); end join_none
        for (int i = 0; i < 3; i++) begin
            uart_tx_valid = 1;
            uart_tx_bit = i == 1;
            step(1);
        end
        uart_tx_valid = 0;
        step(2);
        wait_idle;
        chk("pulses", 2, peer.pulses - n);
        chk("span", 32, peer.span);
        chk("width", 3, peer.width);
        chk("txd_pin", 0, txd_pin);
    endtask
    task t_fill;
        n = 0;
        uart_tx_bit = 1;
        uart_tx_valid = 1;
        for (int k = 0; k < 40; k++) begin
            if (uart_tx_ready === 1'b0) n = 1;
            step(1);
        end
        uart_tx_valid = 0;
        chk("full", 1, n);
        wait_idle;
        chk("uart_tx_ready", 1, uart_tx_ready);
    endtask
    task watch_rx;
        f = -1;
        l = -1;
        for (int k = 0; k < 80; k++) begin
            step(1);
            if (uart_rxd !== 1'b1) begin
                if (f < 0) f = k;
                l = k;
            end
        end
    endtask
    task t_gap(input int gap, input int low);
        fork peer.pair(gap); join_none
        watch_rx;
        chk("lag", 9, f);
        chk("gap_low", low, l - f + 1);
        chk("rx_active", 0, rx_active);
    endtask
    task t_rx(input int zeros);
        fork begin
            for (int z = 0; z < zeros + 2; z++) peer.send(z >= zeros);
        end join_none
        watch_rx;
        chk("lag", 1, f >= 7 && f <= 12);
        chk("low", 16 * zeros, l - f + 1);
        chk("uart_rxd", 1, uart_rxd);
        chk("rx_active", 0, rx_active);
    endtask
    task t_rate;
        baud_divisor = 16'h0003;
        step(3);
        n = 0;
        for (int k = 0; k < 30; k++) begin
            n += baud_tick_out;
            step(1);
        end
        chk("ticks", 10, n);
        baud_divisor = 16'h0001;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        step(2);
        chk("txd_pin", 1, txd_pin);
        chk("uart_rxd", 1, uart_rxd);
        chk("uart_tx_ready", 0, uart_tx_ready);
        step(2);
        resetn = 1;
        uart_enable = 1;
        step(2);
        t_pass;
        infrared_enable_bit = 1;
        step(3);
        t_tx;
        t_fill;
        t_rx(1);
        t_rx(2);
        t_gap(11, 16);
        t_gap(12, 28);
        t_gap(24, 40);
        t_rate;
        conclude;
    end
endmodule
bind ire_endec ire_endec_assertions #(.DIV_WIDTH(DIV_WIDTH)) chk_i (
    .core_clk(core_clk), .resetn(resetn), .uart_enable(uart_enable),
    .infrared_enable_bit(infrared_enable_bit), .baud_divisor(baud_divisor),
    .uart_txd(uart_txd), .uart_tx_valid(uart_tx_valid),
    .uart_tx_bit(uart_tx_bit), .uart_tx_ready(uart_tx_ready),
    .txd_pin(txd_pin), .ir_pulse_in(ir_pulse_in), .uart_rxd(uart_rxd),
    .baud_tick_out(baud_tick_out), .tx_busy(tx_busy), .rx_active(rx_active));
`default_nettype wire
